// [design/mrs_delay_counter.v]
// Down counter that times the start-up and option-load delays
`timescale 1ns/1ps
module mrs_delay_counter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        load,
  input  wire [10:0] load_val,
  output reg         busy_reg,
  output reg         done_reg
);
  reg [10:0] cnt_reg;

  ////////////////////////////////////////////////////////////
  // Load restarts the delay; done pulses on the last count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 11'h000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (load) begin
        cnt_reg  <= load_val;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg == 11'h001) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        cnt_reg <= cnt_reg - 11'h001;
      end
    end
  end
endmodule

// [design/mrs_reset_sequencer.v]
// Reset sequencer: reset sources, start-up and option delays, cause flags, APB registers
`timescale 1ns/1ps
`include "mrs_defines.vh"

// Function
// - A reset starts from the pin in normal run, the pin during halt, or watchdog expiry in normal run.
// - Watchdog expiry during halt gives a warm reset that clears only the program counter and stack pointer.
// - Every non-warm reset returns most registers to initial values while some keep their contents.
// - Power-up clears both flags, a pin reset in run keeps them, a pin wake from halt gives timeout 0 and halt 1.
// - Watchdog expiry sets timeout to 1, keeping halt in run and setting halt when halted.
// - A start-up delay of 1024 clocks follows power-up, watchdog expiry and pin reset.
// - For a system reset the start-up delay runs inside the reset period with the core held in reset.
// - Every wake-up from halt also waits the start-up delay before execution resumes.
// - Power-up, run-mode watchdog expiry and pin reset add an option-load delay, halt wake-up does not.
// - Chip reset sets the program counter to 000H, disables interrupts, stops the timer and makes ports inputs.
// - Chip reset clears the watchdog counter, which counts again once the master reset ends.
// - Chip reset points the stack pointer at the top of the stack.
// - Entering halt sets the halt flag and clears the timeout flag.
// - The halt flag is cleared by power-up and watchdog clear and set by the halt instruction or a pin or watchdog wake from halt.
module mrs_reset_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_init_pin_n,
  input  wire        wdt_expire,
  output reg         core_reset_reg,
  output reg         halted_reg,
  output reg         watchdog_expired_flag,
  output reg         halt_entered_flag,
  output reg         watchdog_clear_reg,
  output reg  [10:0] pc_reg,
  output reg  [2:0]  stack_pointer,
  output reg  [6:0]  intc_reg,
  output reg  [7:0]  tmrc_reg,
  output reg  [7:0]  port_latch_reg,
  output reg  [7:0]  port_dir_reg,
  output reg         irq
);
  // Sequencer states
  localparam ST_RUN  = 3'd0;
  localparam ST_SST  = 3'd1;
  localparam ST_OPT  = 3'd2;
  localparam ST_WAKE = 3'd3;
  localparam ST_HALT = 3'd4;

  // Delay lengths in clock cycles
  localparam [10:0] SST_LEN = `MRS_SST_CYCLES;
  localparam [10:0] OPT_LEN = `MRS_OPT_CYCLES;

  reg  [2:0]  state_reg;
  reg         pin_s1_reg;
  reg         pin_s2_reg;
  reg         pin_prev_reg;
  reg         wdt_s1_reg;
  reg         wdt_s2_reg;
  reg         wdt_prev_reg;
  reg         pwr_up_reg;
  reg  [3:0]  irq_st_reg;
  reg  [3:0]  irq_mask_reg;
  reg  [3:0]  ev_set;
  reg         dly_load;
  reg  [10:0] dly_val;
  reg         chip_rst;
  reg         warm_rst;
  wire        dly_busy;
  wire        dly_done;
  wire        pin_fall;
  wire        wdt_rise;
  wire        wr_en;
  wire        rd_en;

  // Address decode shared by read and write paths
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `MRS_ADDR_PC);
    end
  endfunction

  mrs_delay_counter u_dly (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (dly_load),
    .load_val (dly_val),
    .busy_reg (dly_busy),
    .done_reg (dly_done)
  );

  ////////////////////////////////////////////////////////////
  // Pin and watchdog inputs cross in through two flops each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg   <= 1'b1;
      pin_s2_reg   <= 1'b1;
      pin_prev_reg <= 1'b1;
      wdt_s1_reg   <= 1'b0;
      wdt_s2_reg   <= 1'b0;
      wdt_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= ext_init_pin_n;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      wdt_s1_reg   <= wdt_expire;
      wdt_s2_reg   <= wdt_s1_reg;
      wdt_prev_reg <= wdt_s2_reg;
    end
  end

  assign pin_fall = pin_prev_reg & ~pin_s2_reg;
  assign wdt_rise = wdt_s2_reg & ~wdt_prev_reg;
  assign wr_en    = psel & penable & pwrite & is_mapped(paddr);
  assign rd_en    = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////
  // Reset source selection; pin wins over watchdog in the same cycle
  always @* begin
    chip_rst = 1'b0;
    warm_rst = 1'b0;
    dly_load = 1'b0;
    dly_val  = SST_LEN;
    if (pwr_up_reg) begin
      chip_rst = 1'b1;
    end else if (pin_fall) begin
      chip_rst = 1'b1;
    end else if (wdt_rise && state_reg != ST_HALT) begin
      chip_rst = 1'b1;
    end else if (wdt_rise && state_reg == ST_HALT) begin
      warm_rst = 1'b1;
    end
    if (chip_rst || warm_rst) begin
      dly_load = 1'b1;
    end else if (state_reg == ST_HALT && wr_en && paddr == `MRS_ADDR_CTRL && pwdata[`MRS_CTRL_WAKE]) begin
      dly_load = 1'b1;
    end else if (state_reg == ST_SST && dly_done) begin
      dly_load = 1'b1;
      dly_val  = OPT_LEN;
    end
  end

  ////////////////////////////////////////////////////////////
  // Sequencer; after a chip reset the core is held in reset across start-up and option delays
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_SST;
      core_reset_reg <= 1'b1;
      halted_reg     <= 1'b0;
      pwr_up_reg     <= 1'b1;
    end else begin
      pwr_up_reg <= 1'b0;
      if (chip_rst) begin
        state_reg      <= ST_SST;
        core_reset_reg <= 1'b1;
        halted_reg     <= 1'b0;
      end else if (warm_rst) begin
        state_reg  <= ST_WAKE;
        halted_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_SST: begin
            if (dly_done) begin
              state_reg <= ST_OPT;
            end
          end
          ST_OPT: begin
            if (dly_done) begin
              state_reg      <= ST_RUN;
              core_reset_reg <= 1'b0;
            end
          end
          ST_WAKE: begin
            if (dly_done) begin
              state_reg <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (wr_en && paddr == `MRS_ADDR_CTRL && pwdata[`MRS_CTRL_HALT]) begin
              state_reg  <= ST_HALT;
              halted_reg <= 1'b1;
            end
          end
          ST_HALT: begin
            if (dly_load) begin
              state_reg  <= ST_WAKE;
              halted_reg <= 1'b0;
            end
          end
          default: begin
            state_reg <= ST_SST;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Cause flags; both flags are cleared by the bus reset and again by power-up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_expired_flag <= 1'b0;
      halt_entered_flag     <= 1'b0;
    end else if (pwr_up_reg) begin
      watchdog_expired_flag <= 1'b0;
      halt_entered_flag     <= 1'b0;
    end else if (pin_fall) begin
      if (state_reg == ST_HALT) begin
        watchdog_expired_flag <= 1'b0;
        halt_entered_flag     <= 1'b1;
      end
    end else if (wdt_rise) begin
      watchdog_expired_flag <= 1'b1;
      if (state_reg == ST_HALT) begin
        halt_entered_flag <= 1'b1;
      end
    end else if (state_reg == ST_RUN && wr_en && paddr == `MRS_ADDR_CTRL) begin
      if (pwdata[`MRS_CTRL_HALT]) begin
        halt_entered_flag     <= 1'b1;
        watchdog_expired_flag <= 1'b0;
      end else if (pwdata[`MRS_CTRL_WDCLR]) begin
        halt_entered_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Functional unit state; warm reset touches only PC and stack pointer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg             <= `MRS_PC_RESET;
      stack_pointer      <= `MRS_SP_TOP;
      intc_reg           <= `MRS_INTC_RESET;
      tmrc_reg           <= `MRS_TMRC_RESET;
      port_latch_reg     <= `MRS_PORT_RESET;
      port_dir_reg       <= `MRS_PORT_RESET;
      watchdog_clear_reg <= 1'b1;
    end else if (chip_rst) begin
      pc_reg             <= `MRS_PC_RESET;
      stack_pointer      <= `MRS_SP_TOP;
      intc_reg           <= `MRS_INTC_RESET;
      tmrc_reg           <= `MRS_TMRC_RESET;
      port_latch_reg     <= `MRS_PORT_RESET;
      port_dir_reg       <= `MRS_PORT_RESET;
      watchdog_clear_reg <= 1'b1;
    end else if (warm_rst) begin
      pc_reg        <= `MRS_PC_RESET;
      stack_pointer <= `MRS_SP_TOP;
    end else begin
      // Watchdog held clear while the core is in reset, counts after
      watchdog_clear_reg <= core_reset_reg | (wr_en && paddr == `MRS_ADDR_CTRL &&
                            (pwdata[`MRS_CTRL_WDCLR] | pwdata[`MRS_CTRL_HALT]));
      if (wr_en) begin
        case (paddr)
          `MRS_ADDR_INTC: intc_reg       <= pwdata[6:0];
          `MRS_ADDR_TMRC: tmrc_reg       <= {pwdata[7:6], 1'b0, pwdata[4:0]};
          `MRS_ADDR_PORT: port_latch_reg <= pwdata[7:0];
          `MRS_ADDR_DIR:  port_dir_reg   <= pwdata[7:0];
          `MRS_ADDR_PC:   pc_reg         <= pwdata[10:0];
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Event sources for the interrupt status
  always @* begin
    ev_set = 4'h0;
    ev_set[`MRS_EV_CHIP] = chip_rst & ~pwr_up_reg;
    ev_set[`MRS_EV_WARM] = warm_rst;
    ev_set[`MRS_EV_WAKE] = (state_reg == ST_WAKE) & dly_done;
    ev_set[`MRS_EV_DONE] = (state_reg == ST_OPT) & dly_done;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg   <= 4'h0;
      irq_mask_reg <= 4'h0;
      irq          <= 1'b0;
    end else begin
      if (wr_en && paddr == `MRS_ADDR_IRQ_ST) begin
        irq_st_reg <= (irq_st_reg & ~pwdata[3:0]) | ev_set;
      end else begin
        irq_st_reg <= irq_st_reg | ev_set;
      end
      if (wr_en && paddr == `MRS_ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[3:0];
      end
      irq <= |(irq_st_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////
  // APB slave: answers in the first access cycle, read data captured in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~is_mapped(paddr);
      if (rd_en) begin
        case (paddr)
          `MRS_ADDR_CTRL:     prdata <= {29'h0, halted_reg, 2'b00};
          `MRS_ADDR_STAT:     prdata <= {26'h0, state_reg, core_reset_reg,
                                         halt_entered_flag, watchdog_expired_flag};
          `MRS_ADDR_IRQ_ST:   prdata <= {28'h0, irq_st_reg};
          `MRS_ADDR_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
          `MRS_ADDR_INTC:     prdata <= {25'h0, intc_reg};
          `MRS_ADDR_TMRC:     prdata <= {24'h0, tmrc_reg};
          `MRS_ADDR_PORT:     prdata <= {24'h0, port_latch_reg};
          `MRS_ADDR_DIR:      prdata <= {24'h0, port_dir_reg};
          `MRS_ADDR_PC:       prdata <= {21'h0, pc_reg};
          default:            prdata <= 32'h00000000;
        endcase
      end else if (psel & ~penable) begin
        // Writes return zero data so no stale read value leaks onto the bus
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

// [inc/mrs_defines.vh]
// Constants for the reset sequencer: delays, reset values, APB map
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
`define MRS_CLK_HZ          40000000
`define MRS_SST_CYCLES      11'd1024
`define MRS_OPT_CYCLES      11'd16
`define MRS_PC_RESET        11'h000
`define MRS_SP_TOP          3'h0
`define MRS_INTC_RESET      7'h00
`define MRS_TMRC_RESET      8'h08
`define MRS_PORT_RESET      8'hff
`define MRS_ADDR_CTRL       12'h000
`define MRS_ADDR_STAT       12'h004
`define MRS_ADDR_IRQ_ST     12'h008
`define MRS_ADDR_IRQ_MASK   12'h00c
`define MRS_ADDR_INTC       12'h010
`define MRS_ADDR_TMRC       12'h014
`define MRS_ADDR_PORT       12'h018
`define MRS_ADDR_DIR        12'h01c
`define MRS_ADDR_PC         12'h020
`define MRS_CTRL_HALT       0
`define MRS_CTRL_WDCLR      1
`define MRS_CTRL_WAKE       2
`define MRS_EV_CHIP         0
`define MRS_EV_WARM         1
`define MRS_EV_WAKE         2
`define MRS_EV_DONE         3
`endif

// [verification/mrs_pin_model.sv]
// External reset circuit model driving the active-low init pin
`timescale 1ns/1ps
module mrs_pin_model #(
  parameter LOW_CYCLES = 8
) (
  input  logic pclk,
  input  logic start,
  output logic ext_init_pin_n
);
  int cnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Pin is pulled up, so it reads high as soon as the circuit lets go
  always @(posedge pclk) begin
    if (start) cnt <= LOW_CYCLES;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign ext_init_pin_n = (cnt == 0);
endmodule

// [verification/mrs_reset_sequencer_assertions.sv]
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
module mrs_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        core_reset_reg,
  input logic        halted_reg,
  input logic        watchdog_expired_flag,
  input logic        halt_entered_flag,
  input logic        watchdog_clear_reg,
  input logic [10:0] pc_reg,
  input logic [2:0]  stack_pointer,
  input logic [6:0]  intc_reg,
  input logic [7:0]  tmrc_reg,
  input logic [7:0]  port_latch_reg,
  input logic [7:0]  port_dir_reg
);
  logic [11:0] hold_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles spent in core reset; wide enough that a stuck reset shows as too long
  always @(posedge pclk or negedge presetn)
    if (!presetn) hold_cnt <= 12'h000;
    else hold_cnt <= core_reset_reg ? hold_cnt + 12'h001 : 12'h000;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_enter;
    $rose(core_reset_reg);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ready_next: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("answer held too long");
  a_unmapped_err: assert property (s_setup ##0 (paddr > 12'h020) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_chip_core: assert property (s_enter |-> pc_reg == 11'h000 && stack_pointer == 3'h0)
    else $error("core state not reset");
  a_chip_units: assert property (s_enter |-> intc_reg == 7'h00 && tmrc_reg == 8'h08
    && port_latch_reg == 8'hff && port_dir_reg == 8'hff) else $error("unit state not reset");
  a_wdclr_reset: assert property (core_reset_reg |-> watchdog_clear_reg) else $error("watchdog not cleared");
  a_reset_length: assert property ($fell(core_reset_reg) |-> hold_cnt >= 12'h410 && hold_cnt <= 12'h44c)
    else $error("reset period length wrong");
  a_halt_flags: assert property ($rose(halted_reg) |-> ##[0:1] (halt_entered_flag && !watchdog_expired_flag))
    else $error("halt entry flags wrong");
endmodule

bind mrs_reset_sequencer mrs_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .core_reset_reg, .halted_reg, .watchdog_expired_flag, .halt_entered_flag, .watchdog_clear_reg, .pc_reg,
  .stack_pointer, .intc_reg, .tmrc_reg, .port_latch_reg, .port_dir_reg);

// [verification/mrs_reset_sequencer_tb.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "mrs_defines.vh"
module mrs_reset_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, pin_go, wdt_expire, ext_init_pin_n;
  logic        core_reset_reg, halted_reg, watchdog_expired_flag, halt_entered_flag, watchdog_clear_reg, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [10:0] pc_reg;
  logic [2:0]  stack_pointer;
  logic [6:0]  intc_reg;
  logic [7:0]  tmrc_reg, port_latch_reg, port_dir_reg;
  int          err_count = 0, n_checks = 0, cyc;
  mrs_reset_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_init_pin_n, .wdt_expire, .core_reset_reg, .halted_reg, .watchdog_expired_flag, .halt_entered_flag,
    .watchdog_clear_reg, .pc_reg, .stack_pointer, .intc_reg, .tmrc_reg, .port_latch_reg, .port_dir_reg, .irq);
  mrs_pin_model #(.LOW_CYCLES(8)) u_pin (.pclk(pclk), .start(pin_go), .ext_init_pin_n(ext_init_pin_n));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or the bench watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Bounded wait for an unmasked event, then every event is cleared
  task automatic wait_irq;
    cyc = 0;
    while (irq !== 1'b1 && cyc < 3000) begin
      @(posedge pclk);
      cyc++;
    end
    chk(irq, 1'b1);
    apb(1'b1, `MRS_ADDR_IRQ_ST, 32'hf);
  endtask
  // Held a few cycles so the two-flop synchroniser cannot miss it
  task automatic wdt_pulse;
    wdt_expire <= 1'b1;
    repeat (4) @(posedge pclk);
    wdt_expire <= 1'b0;
  endtask
  task automatic pin_pulse;
    pin_go <= 1'b1;
    @(posedge pclk);
    pin_go <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    err_count++;
    stop_test;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wdt_expire = 1'b0;
    pin_go = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(core_reset_reg, 1'b1);
    apb(1'b1, `MRS_ADDR_IRQ_MASK, 32'h8);
    wait_irq;
    chk(cyc inside {[1000:1070]}, 1'b1);
    chk({watchdog_expired_flag, halt_entered_flag}, 2'b00);
    chk({pc_reg, stack_pointer}, 14'h0000);
    chk({intc_reg, tmrc_reg, port_latch_reg, port_dir_reg}, {7'h00, 8'h08, 16'hffff});
    rd(`MRS_ADDR_STAT, 32'h0);
    rd(12'h024, 32'h0);
    chk(rerr, 1'b1);
    $display("test power-up done");
    apb(1'b1, `MRS_ADDR_INTC, 32'h55);
    apb(1'b1, `MRS_ADDR_TMRC, 32'h3f);
    rd(`MRS_ADDR_TMRC, 32'h1f);
    apb(1'b1, `MRS_ADDR_PORT, 32'h0f);
    apb(1'b1, `MRS_ADDR_DIR, 32'h00);
    apb(1'b1, `MRS_ADDR_IRQ_MASK, 32'h0);
    wdt_pulse;
    repeat (1100) @(posedge pclk);
    chk(irq, 1'b0);
    rd(`MRS_ADDR_IRQ_ST, 32'h9);
    chk({watchdog_expired_flag, halt_entered_flag}, 2'b10);
    chk({intc_reg, tmrc_reg, port_latch_reg, port_dir_reg}, {7'h00, 8'h08, 16'hffff});
    apb(1'b1, `MRS_ADDR_IRQ_MASK, 32'h8);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, `MRS_ADDR_IRQ_ST, 32'hf);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test watchdog run done");
    apb(1'b1, `MRS_ADDR_INTC, 32'h55);
    apb(1'b1, `MRS_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk({halted_reg, watchdog_expired_flag, halt_entered_flag}, 3'b101);
    wdt_pulse;
    repeat (1100) @(posedge pclk);
    chk({watchdog_expired_flag, halt_entered_flag}, 2'b11);
    chk({core_reset_reg, halted_reg, pc_reg, intc_reg}, {13'h0000, 7'h55});
    $display("test warm reset done");
    apb(1'b1, `MRS_ADDR_CTRL, 32'h2);
    // The write lands on the edge the task returns at; look one edge later
    @(posedge pclk);
    chk({watchdog_expired_flag, halt_entered_flag}, 2'b10);
    pin_pulse;
    wait_irq;
    chk({watchdog_expired_flag, halt_entered_flag}, 2'b10);
    chk(intc_reg, 7'h00);
    apb(1'b1, `MRS_ADDR_INTC, 32'h55);
    apb(1'b1, `MRS_ADDR_CTRL, 32'h1);
    pin_pulse;
    wait_irq;
    chk({halted_reg, watchdog_expired_flag, halt_entered_flag}, 3'b001);
    chk(intc_reg, 7'h00);
    $display("test pin reset done");
    apb(1'b1, `MRS_ADDR_CTRL, 32'h1);
    apb(1'b1, `MRS_ADDR_IRQ_MASK, 32'h4);
    apb(1'b1, `MRS_ADDR_CTRL, 32'h4);
    wait_irq;
    chk(cyc inside {[1020:1035]}, 1'b1);
    chk({core_reset_reg, halted_reg}, 2'b00);
    $display("test wake done");
    stop_test;
  end
endmodule
